// ==== usbh_regbank.sv ====
// command decoder and register bank of the embedded host controller
`timescale 1ns/10ps
`include "usbh_cfg.svh"
module usbh_regbank #(
    parameter logic [7:0]  REV_BCD = 8'h21,    // arbitrary value
    parameter logic [15:0] PART_ID = 16'h5A3C, // arbitrary value
    parameter int          NRW     = 15        // plain read/write slots
) (
    input  wire logic               core_clk_i,     // system clock, 25 MHz
    input  wire logic               rst_i,          // synchronous reset, high
    input  wire logic               cmd_strobe_i,   // command code present, pulse
    input  wire logic [7:0]         cmd_code_i,     // command code
    input  wire logic               data_wr_i,      // write half word, pulse
    input  wire usbh_pkg::usbh_half_t data_i,       // written half word
    input  wire logic               data_rd_i,      // read half word, pulse
    input  wire usbh_pkg::usbh_word_t fm_remaining_i, // frame time left
    input  wire usbh_pkg::usbh_word_t fm_number_i,  // frame index
    input  wire usbh_pkg::usbh_half_t buf_state_i,  // buffer state
    input  wire usbh_pkg::usbh_half_t iso0_fill_i,  // iso bank 0 fill
    input  wire usbh_pkg::usbh_half_t iso1_fill_i,  // iso bank 1 fill
    input  wire usbh_pkg::usbh_word_t evt_set_i,    // hardware event set pulses
    input  wire usbh_pkg::usbh_word_t cmd_done_i,   // command status clear pulses
    input  wire usbh_pkg::usbh_half_t cpu_set_i,    // cpu event set pulses
    input  wire usbh_pkg::usbh_half_t window_rd_data_i, // buffer ram read word
    output usbh_pkg::usbh_half_t    rd_data_o,      // read half word
    output logic                    rd_valid_o,     // read half word valid, pulse
    output logic [1:0]              hc_state_o,     // functional state field
    output logic                    remote_wake_o,  // remote wakeup signalled
    output logic                    soft_reset_o,   // soft reset, pulse
    output usbh_pkg::usbh_word_t    evt_status_o,   // event status flags
    output usbh_pkg::usbh_word_t    evt_enable_o,   // event enable mask
    output usbh_pkg::usbh_word_t    cmd_status_o,   // command status bits
    output usbh_pkg::usbh_half_t    cpu_flags_o,    // cpu event flags
    output usbh_pkg::usbh_half_t    hw_setup_o,     // hardware setup register
    output logic                    window_wr_o,    // buffer ram write, pulse
    output logic                    window_rd_o,    // buffer ram read, pulse
    output logic                    window_sel_o,   // 1 async list, 0 iso list
    output usbh_pkg::usbh_half_t    window_data_o   // buffer ram write word
);
    import usbh_pkg::*;

    // the slot table is sized for exactly fifteen plain registers
    if (NRW != 15) begin : g_bad_nrw
        $error("usbh_regbank: slot count must be 15");
    end

    usbh_phase_t             phase;
    usbh_phase_t             next_phase;
    logic [6:0]              cur_code;
    logic                    word_hi;
    usbh_half_t              hold_lo;
    usbh_word_t              rd_shadow;
    logic [NRW-1:0][31:0]    rw_q;
    usbh_word_t              evt_status;
    usbh_word_t              evt_enable;
    usbh_word_t              cmd_status;
    usbh_half_t              cpu_flags;

    // map a read code to its storage slot
    function automatic usbh_slot_t slot_of(input logic [6:0] code);
        case (code)
            `USBH_CMD_CONTROL:      slot_of = `USBH_SLOT_CONTROL;
            `USBH_CMD_FM_INTERVAL:  slot_of = `USBH_SLOT_FM_INTERVAL;
            `USBH_CMD_LS_THRESHOLD: slot_of = `USBH_SLOT_LS_THRESHOLD;
            `USBH_CMD_RH_DESC_A:    slot_of = `USBH_SLOT_RH_DESC_A;
            `USBH_CMD_RH_DESC_B:    slot_of = `USBH_SLOT_RH_DESC_B;
            `USBH_CMD_RH_STATUS:    slot_of = `USBH_SLOT_RH_STATUS;
            `USBH_CMD_PORT_ONE:     slot_of = `USBH_SLOT_PORT_ONE;
            `USBH_CMD_PORT_TWO:     slot_of = `USBH_SLOT_PORT_TWO;
            `USBH_CMD_HW_SETUP:     slot_of = `USBH_SLOT_HW_SETUP;
            `USBH_CMD_DMA_SETUP:    slot_of = `USBH_SLOT_DMA_SETUP;
            `USBH_CMD_XFER_COUNT:   slot_of = `USBH_SLOT_XFER_COUNT;
            `USBH_CMD_CPU_MASK:     slot_of = `USBH_SLOT_CPU_MASK;
            `USBH_CMD_SCRATCH:      slot_of = `USBH_SLOT_SCRATCH;
            `USBH_CMD_ISO_LEN:      slot_of = `USBH_SLOT_ISO_LEN;
            `USBH_CMD_ASYNC_LEN:    slot_of = `USBH_SLOT_ASYNC_LEN;
            default:                slot_of = `USBH_SLOT_NONE;
        endcase
    endfunction

    // value seen by a read command; unknown codes read zero
    function automatic usbh_word_t read_of(input logic [6:0] code);
        usbh_slot_t s;
        s = slot_of(code);
        case (code)
            `USBH_CMD_REVISION:     read_of = {`USBH_REV_PAD, REV_BCD};
            `USBH_CMD_CMD_STATUS:   read_of = cmd_status;
            `USBH_CMD_EVT_STATUS:   read_of = evt_status;
            `USBH_CMD_EVT_EN_SET,
            `USBH_CMD_EVT_EN_CLR:   read_of = evt_enable;
            `USBH_CMD_FM_REMAINING: read_of = fm_remaining_i;
            `USBH_CMD_FM_NUMBER:    read_of = fm_number_i;
            `USBH_CMD_CPU_FLAGS:    read_of = {`USBH_RESET_HALF, cpu_flags};
            `USBH_CMD_PART_ID:      read_of = {`USBH_RESET_HALF, PART_ID};
            `USBH_CMD_BUF_STATE:    read_of = {`USBH_RESET_HALF, buf_state_i};
            `USBH_CMD_ISO0_FILL:    read_of = {`USBH_RESET_HALF, iso0_fill_i};
            `USBH_CMD_ISO1_FILL:    read_of = {`USBH_RESET_HALF, iso1_fill_i};
            // the soft reset code has no read function and returns zero
            default: read_of = (s == `USBH_SLOT_NONE) ? `USBH_RESET_WORD : rw_q[s];
        endcase
    endfunction

    // command decode: top bit selects write, the rest is the read code
    wire        cmd_is_wr   = cmd_code_i[`USBH_WR_BIT];
    wire [6:0]  cmd_base    = cmd_code_i[6:0];
    wire        cur_wide    = (cur_code < `USBH_CMD_WIDE_LIMIT);
    wire        cur_window  = (cur_code == `USBH_CMD_ISO_WINDOW) ||
                              (cur_code == `USBH_CMD_ASYNC_WINDOW);
    wire        in_wr       = (phase == USBH_WR);
    wire        in_rd       = (phase == USBH_RD);
    // a 32-bit register commits on its upper half so it changes in one step
    wire        wr_commit   = in_wr && data_wr_i && (!cur_wide || word_hi);
    wire usbh_word_t wdata  = cur_wide ? {data_i, hold_lo} : {`USBH_RESET_HALF, data_i};
    wire usbh_slot_t wslot  = slot_of(cur_code);
    wire        wr_soft     = wr_commit && (cur_code == `USBH_CMD_SOFT_RESET);
    wire        wr_evt      = wr_commit && (cur_code == `USBH_CMD_EVT_STATUS);
    wire        wr_en_set   = wr_commit && (cur_code == `USBH_CMD_EVT_EN_SET);
    wire        wr_en_clr   = wr_commit && (cur_code == `USBH_CMD_EVT_EN_CLR);
    wire        wr_cmd_st   = wr_commit && (cur_code == `USBH_CMD_CMD_STATUS);
    wire        wr_cpu      = wr_commit && (cur_code == `USBH_CMD_CPU_FLAGS);
    wire        wr_window   = in_wr && data_wr_i && cur_window;
    wire        rd_window   = in_rd && data_rd_i && cur_window;
    wire        wr_ctl      = wr_commit && (wslot == `USBH_SLOT_CONTROL);

    // next phase; a new command always wins over a half-finished one
    always_comb begin
        next_phase = phase;
        case (phase)
            USBH_IDLE,
            USBH_WR,
            USBH_RD: begin
                if (cmd_strobe_i) begin
                    next_phase = cmd_is_wr ? USBH_WR : USBH_RD;
                end
            end
            default: next_phase = USBH_IDLE;
        endcase
    end

    // command and half-word sequencing
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            phase    <= USBH_IDLE;
            cur_code <= `USBH_RESET_CODE;
            word_hi  <= 1'b0;
            hold_lo  <= `USBH_RESET_HALF;
        end else begin
            phase <= next_phase;
            if (cmd_strobe_i) begin
                cur_code <= cmd_base;
                word_hi  <= 1'b0;
            end else if ((in_wr && data_wr_i) || (in_rd && data_rd_i)) begin
                word_hi <= cur_wide ? ~word_hi : 1'b0;
                if (in_wr && !word_hi) begin
                    hold_lo <= data_i;
                end
            end
        end
    end

    // read path: the whole register is caught at the command, so both halves agree
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            rd_shadow  <= `USBH_RESET_WORD;
            rd_data_o  <= `USBH_RESET_HALF;
            rd_valid_o <= 1'b0;
        end else begin
            rd_valid_o <= in_rd && data_rd_i;
            if (cmd_strobe_i && !cmd_is_wr) begin
                rd_shadow <= read_of(cmd_base);
            end
            if (rd_window) begin
                rd_data_o <= window_rd_data_i;
            end else if (in_rd && data_rd_i) begin
                rd_data_o <= word_hi ? rd_shadow[31:16] : rd_shadow[15:0];
            end
        end
    end

    // plain read/write registers; only a driver write commit or a soft reset changes them
    // the mode control slot alone keeps its wakeup-connected bit over a soft reset
    for (genvar k = 0; k < NRW; k++) begin : g_rw
        usbh_reg_cell #(
            .W     (32),
            .RESET (`USBH_RESET_WORD),
            .KEEP  ((k == int'(`USBH_SLOT_CONTROL)) ? `USBH_CTL_KEEP : `USBH_RESET_WORD)
        ) u_cell (
            .core_clk_i (core_clk_i),
            .rst_i      (rst_i),
            .we_i       (wr_commit && (wslot == usbh_slot_t'(k))),
            .clr_i      (soft_reset_o),
            .d_i        (wdata),
            .q_o        (rw_q[k])
        );
    end

    // event and cpu flags hardware sets and the driver clears, plus command bits and enable mask; a set in the clear cycle wins
    always_ff @(posedge core_clk_i) begin
        if (rst_i || soft_reset_o) begin
            evt_status <= `USBH_RESET_WORD;
            evt_enable <= `USBH_RESET_WORD;
            cmd_status <= `USBH_RESET_WORD;
            cpu_flags  <= `USBH_RESET_HALF;
        end else begin
            evt_status <= (evt_status & ~(wr_evt ? wdata : `USBH_RESET_WORD)) | evt_set_i;
            cpu_flags  <= (cpu_flags & ~(wr_cpu ? wdata[15:0] : `USBH_RESET_HALF)) | cpu_set_i;
            // command bits are write-one-to-set; completion clears them
            cmd_status <= (cmd_status & ~cmd_done_i) | (wr_cmd_st ? wdata : `USBH_RESET_WORD);
            if (wr_en_set) begin
                evt_enable <= evt_enable | wdata;
            end else if (wr_en_clr) begin
                evt_enable <= evt_enable & ~wdata;
            end
        end
    end

    // side effects: soft reset pulse, buffer window strobes, wakeup request
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            soft_reset_o  <= 1'b0;
            window_wr_o   <= 1'b0;
            window_rd_o   <= 1'b0;
            window_sel_o  <= 1'b0;
            window_data_o <= `USBH_RESET_HALF;
            remote_wake_o <= 1'b0;
        end else begin
            soft_reset_o  <= wr_soft;
            window_wr_o   <= wr_window;
            window_rd_o   <= rd_window;
            window_sel_o  <= (cur_code == `USBH_CMD_ASYNC_WINDOW);
            window_data_o <= data_i;
            remote_wake_o <= rw_q[`USBH_SLOT_CONTROL][`USBH_CTL_RWE] &&
                             evt_status[`USBH_EVT_RESUME];
        end
    end

    // register-driven views; all come straight from flip-flops
    assign hc_state_o   = rw_q[`USBH_SLOT_CONTROL][`USBH_CTL_STATE_HI:`USBH_CTL_STATE_LO];
    assign evt_status_o = evt_status;
    assign evt_enable_o = evt_enable;
    assign cmd_status_o = cmd_status;
    assign cpu_flags_o  = cpu_flags;
    assign hw_setup_o   = rw_q[`USBH_SLOT_HW_SETUP][15:0];

    // checks
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    sequence s_rev_read;
        cmd_strobe_i && cmd_code_i == {1'b0, `USBH_CMD_REVISION}
            ##1 (!cmd_strobe_i && data_rd_i);
    endsequence

    sequence s_ctl_write;
        cmd_strobe_i && cmd_code_i == {1'b1, `USBH_CMD_CONTROL}
            ##1 (!cmd_strobe_i && data_wr_i)
            ##1 (!cmd_strobe_i && data_wr_i);
    endsequence

    a_rev_value: assert property (s_rev_read |=>
        rd_valid_o && rd_data_o == 16'(REV_BCD))
        else $error("revision low half wrong");

    a_ctl_write: assert property (s_ctl_write |=>
        rw_q[`USBH_SLOT_CONTROL] == {$past(data_i), $past(data_i, 2)})
        else $error("mode control write at 81 hex not stored");

    a_ctl_read: assert property (
        cmd_strobe_i && cmd_code_i == {1'b0, `USBH_CMD_CONTROL} && !soft_reset_o
            |=> rd_shadow == $past(rw_q[`USBH_SLOT_CONTROL]))
        else $error("mode control read at 01 hex wrong");

    a_fm_offset: assert property (
        cmd_strobe_i && cmd_code_i == {1'b0, `USBH_CMD_FM_INTERVAL} && !soft_reset_o
            |=> rd_shadow == $past(rw_q[`USBH_SLOT_FM_INTERVAL]))
        else $error("frame interval read code wrong");

    a_rwe_steady: assert property (!wr_ctl && !soft_reset_o |=>
        $stable(rw_q[`USBH_SLOT_CONTROL][`USBH_CTL_RWE]))
        else $error("remote wakeup enable changed without driver write");

    a_nowrite_calm: assert property (
        in_wr && wslot == `USBH_SLOT_NONE && !soft_reset_o |=> $stable(rw_q))
        else $error("code without write function changed a register");

    a_softrd_calm: assert property (
        cmd_strobe_i && cmd_code_i == {1'b0, `USBH_CMD_SOFT_RESET}
            |=> rd_shadow == `USBH_RESET_WORD ##1 !soft_reset_o)
        else $error("soft reset code read had an effect");

    // second read word of the revision register is the all-zero upper half
    sequence s_rev_both;
        s_rev_read ##1 (!cmd_strobe_i && data_rd_i);
    endsequence

    a_rev_upper: assert property (s_rev_both |=>
        rd_valid_o && rd_data_o == `USBH_RESET_HALF)
        else $error("revision upper half not zero");

    // the wakeup output is only a registered view of enable and resume
    a_wake_level: assert property (
        remote_wake_o == ($past(rw_q[`USBH_SLOT_CONTROL][`USBH_CTL_RWE]) &&
                          $past(evt_status[`USBH_EVT_RESUME])))
        else $error("remote wakeup output lost its enable or resume term");
endmodule

// ==== usbh_cfg.svh ====
// command codes, field positions and reset values of the host register bank
//
// Contract
// - operational register read code equals its standard byte offset over four.
// - mode control register reads at 01 hex, writes at 81 hex.
// - revision register read-only at 00 hex, upper bits zero, low byte BCD version.
// - device logic never alters the remote wakeup enable bit; a soft reset here clears it.
`ifndef USBH_CFG_SVH
`define USBH_CFG_SVH

// read codes; a write code is the read code with the top bit set
`define USBH_WR_BIT            7
`define USBH_CMD_REVISION      7'h00
`define USBH_CMD_CONTROL       7'h01
`define USBH_CMD_CMD_STATUS    7'h02
`define USBH_CMD_EVT_STATUS    7'h03
`define USBH_CMD_EVT_EN_SET    7'h04
`define USBH_CMD_EVT_EN_CLR    7'h05
`define USBH_CMD_FM_INTERVAL   7'h0D
`define USBH_CMD_FM_REMAINING  7'h0E
`define USBH_CMD_FM_NUMBER     7'h0F
`define USBH_CMD_LS_THRESHOLD  7'h11
`define USBH_CMD_RH_DESC_A     7'h12
`define USBH_CMD_RH_DESC_B     7'h13
`define USBH_CMD_RH_STATUS     7'h14
`define USBH_CMD_PORT_ONE      7'h15
`define USBH_CMD_PORT_TWO      7'h16
`define USBH_CMD_HW_SETUP      7'h20
`define USBH_CMD_DMA_SETUP     7'h21
`define USBH_CMD_XFER_COUNT    7'h22
`define USBH_CMD_CPU_FLAGS     7'h24
`define USBH_CMD_CPU_MASK      7'h25
`define USBH_CMD_PART_ID       7'h27
`define USBH_CMD_SCRATCH       7'h28
`define USBH_CMD_SOFT_RESET    7'h29
`define USBH_CMD_ISO_LEN       7'h2A
`define USBH_CMD_ASYNC_LEN     7'h2B
`define USBH_CMD_BUF_STATE     7'h2C
`define USBH_CMD_ISO0_FILL     7'h2D
`define USBH_CMD_ISO1_FILL     7'h2E
`define USBH_CMD_ISO_WINDOW    7'h40
`define USBH_CMD_ASYNC_WINDOW  7'h41
// codes below this one carry 32-bit registers, two half words each
`define USBH_CMD_WIDE_LIMIT    7'h20

// storage slot numbers of the plain read/write registers
`define USBH_SLOT_CONTROL      4'd0
`define USBH_SLOT_FM_INTERVAL  4'd1
`define USBH_SLOT_LS_THRESHOLD 4'd2
`define USBH_SLOT_RH_DESC_A    4'd3
`define USBH_SLOT_RH_DESC_B    4'd4
`define USBH_SLOT_RH_STATUS    4'd5
`define USBH_SLOT_PORT_ONE     4'd6
`define USBH_SLOT_PORT_TWO     4'd7
`define USBH_SLOT_HW_SETUP     4'd8
`define USBH_SLOT_DMA_SETUP    4'd9
`define USBH_SLOT_XFER_COUNT   4'd10
`define USBH_SLOT_CPU_MASK     4'd11
`define USBH_SLOT_SCRATCH      4'd12
`define USBH_SLOT_ISO_LEN      4'd13
`define USBH_SLOT_ASYNC_LEN    4'd14
`define USBH_SLOT_NONE         4'd15

// mode control fields
`define USBH_CTL_RWE           10
`define USBH_CTL_STATE_HI      7
`define USBH_CTL_STATE_LO      6
// bits of the mode control register that survive a soft reset
`define USBH_CTL_KEEP          32'h0000_0200
// resume detected flag of the event status register
`define USBH_EVT_RESUME        6

`define USBH_RESET_WORD        32'h0000_0000
`define USBH_RESET_HALF        16'h0000
`define USBH_RESET_CODE        7'h00
`define USBH_REV_PAD           24'h00_0000

`endif

// ==== usbh_pkg.sv ====
// shared types of the host register bank
package usbh_pkg;
    typedef logic [15:0] usbh_half_t;
    typedef logic [31:0] usbh_word_t;
    typedef logic [3:0]  usbh_slot_t;
    // command phase; idle to write and idle to read each flip one bit
    typedef enum logic [1:0] {
        USBH_IDLE = 2'b00,
        USBH_WR   = 2'b01,
        USBH_RD   = 2'b10
    } usbh_phase_t;
endpackage

// ==== usbh_reg_cell.sv ====
// one read/write register with soft clear that spares selected bits
`timescale 1ns/10ps
module usbh_reg_cell #(
    parameter int                W     = 32,
    parameter logic [W-1:0]      RESET = '0,
    parameter logic [W-1:0]      KEEP  = '0
) (
    input  wire logic            core_clk_i, // system clock
    input  wire logic            rst_i,      // synchronous reset, high
    input  wire logic            we_i,       // commit strobe
    input  wire logic            clr_i,      // soft reset strobe
    input  wire logic [W-1:0]    d_i,        // new contents
    output logic      [W-1:0]    q_o         // stored contents
);
    // widths outside one to thirty-two bits have no read path behind them
    if (W < 1 || W > 32) begin : g_bad_width
        $error("usbh_reg_cell: width out of range");
    end

    // soft reset keeps the bits named in KEEP, the rest go back to reset
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            q_o <= RESET;
        end else if (we_i) begin
            q_o <= d_i;
        end else if (clr_i) begin
            q_o <= (q_o & KEEP) | (RESET & ~KEEP);
        end
    end
endmodule

// ==== usbh_drv_model.sv ====
// behavioural driver processor model that speaks the register command port
`timescale 1ns/10ps
module usbh_drv_model (
    input  wire logic                 core_clk_i,   // system clock
    output logic                      cmd_strobe_o, // command code pulse
    output logic [7:0]                cmd_code_o,   // command code
    output logic                      data_wr_o,    // write half word pulse
    output usbh_pkg::usbh_half_t      data_o,       // written half word
    output logic                      data_rd_o,    // read half word pulse
    input  wire usbh_pkg::usbh_half_t rd_data_i     // returned half word
);
    import usbh_pkg::*;
    // strobes idle low; released lines flip so a stale value never looks fresh
    initial begin
        cmd_strobe_o = 1'b0;
        cmd_code_o   = 8'h00;
        data_wr_o    = 1'b0;
        data_o       = 16'h0000;
        data_rd_o    = 1'b0;
    end
    // every task starts and ends on a falling edge
    task automatic command(input logic [7:0] code);
        cmd_strobe_o = 1'b1;
        cmd_code_o   = code;
        @(negedge core_clk_i);
        cmd_strobe_o = 1'b0;
        cmd_code_o   = ~code;
    endtask
    // n half words, low half first; the high half commits a wide register
    task automatic wr(input logic [7:0] code, input usbh_word_t v, input int n);
        command(code);
        data_wr_o = 1'b1;
        data_o    = v[15:0];
        if (n == 2) begin
            @(negedge core_clk_i);
            data_o = v[31:16];
        end
        @(negedge core_clk_i);
        data_wr_o = 1'b0;
        data_o    = ~data_o;
    endtask
    // read strobe held high over both halves, each word taken as it lands
    task automatic rd(input logic [7:0] code, input int n, output usbh_word_t v);
        command(code);
        v         = 32'h0000_0000;
        data_rd_o = 1'b1;
        @(negedge core_clk_i);
        v[15:0] = rd_data_i;
        if (n == 2) begin
            @(negedge core_clk_i);
            v[31:16] = rd_data_i;
        end
        data_rd_o = 1'b0;
    endtask
    // change only masked bits; reserved bits go back exactly as read
    task automatic rmw(input logic [6:0] code, input usbh_word_t mask, input usbh_word_t val);
        usbh_word_t cur;
        rd({1'b0, code}, 2, cur);
        wr({1'b1, code}, (cur & ~mask) | (val & mask), 2);
    endtask
endmodule

// ==== tb.sv ====
// self-checking bench for the host register bank
`timescale 1ns/10ps
module tb;
    import usbh_pkg::*;
    localparam logic [7:0]  REV = 8'h21;
    localparam logic [15:0] PID = 16'h5A3C;
    localparam logic [7:0]  RW [14] = '{8'h0D, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16,
                                        8'h20, 8'h21, 8'h22, 8'h25, 8'h28, 8'h2A, 8'h2B};
    localparam logic [7:0]  RO [8]  = '{8'h0E, 8'h0F, 8'h2C, 8'h2D, 8'h2E, 8'h27, 8'h29, 8'h40};
    localparam usbh_word_t  RO_EXP [8] = '{32'h0000_2EDF, 32'h0001_0042, 32'h0000_0015,
                                           32'h0000_0100, 32'h0000_0080, {16'h0000, PID},
                                           32'h0000_0000, 32'h0000_BEEF};
    logic       core_clk_i, rst_i, cmd_strobe, data_wr, data_rd, rd_valid;
    logic       remote_wake, soft_reset;
    logic [7:0] cmd_code;
    logic [1:0] hc_state;
    usbh_half_t data, rd_data;
    usbh_word_t evt_set, v, exp_v, evt_status, evt_enable, cmd_status;
    usbh_half_t cpu_set, cpu_flags, hw_setup, window_data;
    logic       window_wr, window_rd, window_sel;
    int         failures, check_count, cycles, n;

    usbh_drv_model drv (.core_clk_i(core_clk_i), .cmd_strobe_o(cmd_strobe),
        .cmd_code_o(cmd_code), .data_wr_o(data_wr), .data_o(data), .data_rd_o(data_rd),
        .rd_data_i(rd_data));
    usbh_regbank #(.REV_BCD(REV), .PART_ID(PID)) usbh_regbank_inst (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .cmd_strobe_i(cmd_strobe),
        .cmd_code_i(cmd_code), .data_wr_i(data_wr), .data_i(data), .data_rd_i(data_rd),
        .fm_remaining_i(RO_EXP[0]), .fm_number_i(RO_EXP[1]), .buf_state_i(RO_EXP[2][15:0]),
        .iso0_fill_i(RO_EXP[3][15:0]), .iso1_fill_i(RO_EXP[4][15:0]), .evt_set_i(evt_set),
        .cmd_done_i(32'h0000_0000), .cpu_set_i(cpu_set), .window_rd_data_i(16'hBEEF),
        .rd_data_o(rd_data), .rd_valid_o(rd_valid), .hc_state_o(hc_state),
        .remote_wake_o(remote_wake), .soft_reset_o(soft_reset), .evt_status_o(evt_status),
        .evt_enable_o(evt_enable), .cmd_status_o(cmd_status), .cpu_flags_o(cpu_flags),
        .hw_setup_o(hw_setup), .window_wr_o(window_wr), .window_rd_o(window_rd),
        .window_sel_o(window_sel), .window_data_o(window_data));

    initial core_clk_i = 1'b0;
    always #20 core_clk_i = ~core_clk_i;

    task automatic check(input usbh_word_t seen, input usbh_word_t exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // read and compare, also requiring the valid pulse on the last word
    task automatic rdc(input logic [7:0] code, input int n, input usbh_word_t exp);
        usbh_word_t got;
        drv.rd(code, n, got);
        check(got, exp);
        check({31'h0, rd_valid}, 32'h0000_0001);
    endtask
    task automatic close_out();
        $display("checks=%0d failures=%0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ceiling well above the fewer than two hundred cycles the sequence needs
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            close_out();
        end
    end

    initial begin
        rst_i   = 1'b1;
        evt_set = 32'h0000_0000;
        cpu_set = 16'h0000;
        repeat (10) @(negedge core_clk_i);
        rst_i = 1'b0;
        rdc(8'h00, 2, {24'h00_0000, REV});
        // fill every plain register except mode control with a pattern that differs per code
        foreach (RW[i]) begin
            drv.wr(RW[i] | 8'h80, {RW[i], 8'h5A, 8'hC3, ~RW[i]}, (RW[i] < 8'h20) ? 2 : 1);
        end
        // write codes without a register, and a read of the reset trigger
        foreach (RO[i]) begin
            // the reset trigger and the buffer window do act on writes, so skip them
            if (RO[i] != 8'h40 && RO[i] != 8'h29) drv.wr(RO[i] | 8'h80, 32'hFFFF_FFFF, 2);
        end
        drv.wr(8'h80, 32'hFFFF_FFFF, 2);
        rdc(8'h29, 1, 32'h0000_0000);
        check({31'h0, soft_reset}, 32'h0000_0000);
        rdc(8'h00, 2, {24'h00_0000, REV});
        foreach (RO[i]) begin
            rdc(RO[i], (RO[i] < 8'h20) ? 2 : 1, RO_EXP[i]);
        end
        foreach (RW[i]) begin
            n     = (RW[i] < 8'h20) ? 2 : 1;
            exp_v = {RW[i], 8'h5A, 8'hC3, ~RW[i]};
            rdc(RW[i], n, (n == 2) ? exp_v : {16'h0000, exp_v[15:0]});
        end
        check({16'h0000, hw_setup}, 32'h0000_C3DF);
        // mode control: operational state plus wakeup enable, reserved bits kept
        drv.rmw(7'h01, 32'h0000_04C0, 32'h0000_0480);
        rdc(8'h01, 2, 32'h0000_0480);
        check({30'h0, hc_state}, 32'h0000_0002);
        check({31'h0, remote_wake}, 32'h0000_0000);
        evt_set[6] = 1'b1;
        @(negedge core_clk_i);
        evt_set[6] = 1'b0;
        repeat (2) @(negedge core_clk_i);
        check({31'h0, remote_wake}, 32'h0000_0001);
        drv.wr(8'h83, 32'h0000_0040, 2);
        rdc(8'h03, 2, 32'h0000_0000);
        rdc(8'h01, 2, 32'h0000_0480);
        check({31'h0, remote_wake}, 32'h0000_0000);
        // set and clear writes carry zeros in every other bit
        drv.wr(8'h84, 32'h0000_0041, 2);
        drv.wr(8'h85, 32'h0000_0001, 2);
        rdc(8'h05, 2, 32'h0000_0040);
        check(evt_enable, 32'h0000_0040);
        drv.wr(8'h82, 32'h0000_0008, 2);
        check(cmd_status, 32'h0000_0008);
        cpu_set[2] = 1'b1;
        @(negedge core_clk_i);
        cpu_set[2] = 1'b0;
        check({16'h0000, cpu_flags}, 32'h0000_0004);
        drv.wr(8'hA4, 32'h0000_0004, 1);
        check({16'h0000, cpu_flags}, 32'h0000_0000);
        // buffer window strobes at the write and read codes
        drv.wr(8'hC1, 32'h0000_1234, 1);
        check({13'h0000, window_rd, window_wr, window_sel, window_data}, 32'h0003_1234);
        rdc(8'h40, 1, 32'h0000_BEEF);
        check({29'h0, window_rd, window_wr, window_sel}, 32'h0000_0004);
        // soft reset keeps only the wakeup-connected bit
        drv.wr(8'h81, 32'h0000_0680, 2);
        drv.wr(8'hA9, 32'h0000_0000, 1);
        check({31'h0, soft_reset}, 32'h0000_0001);
        repeat (2) @(negedge core_clk_i);
        rdc(8'h01, 2, 32'h0000_0200);
        rdc(8'h28, 1, 32'h0000_0000);
        check(evt_enable | cmd_status, 32'h0000_0000);
        rdc(8'h00, 2, {24'h00_0000, REV});
        close_out();
    end
endmodule
